//--- core/rase_pkg.sv
// Package for the read address status encoder.
// Assumes a single 100 MHz core clock and synchronous reset.
package rase_pkg;

  localparam int unsigned PAGE_W       = 6;
  localparam int unsigned STAT_W       = 2;
  localparam int unsigned ADDR_W       = PAGE_W + STAT_W;
  localparam int unsigned CRC_W        = 16;

  localparam logic [PAGE_W-1:0] PAGE_ZERO    = 6'h00;
  localparam logic [PAGE_W-1:0] PAGE_ID      = 6'h03;
  localparam logic [PAGE_W-1:0] PAGE_SPECIAL = 6'h0c;

  localparam logic [STAT_W-1:0] ST_READ_UNLOCKED = 2'h0;
  localparam logic [STAT_W-1:0] ST_PROG_DONE     = 2'h1;
  localparam logic [STAT_W-1:0] ST_READ_LOCKED   = 2'h2;

  // Reader-side timing, kept for reference by the checks
  localparam int unsigned CLK_PERIOD_NS           = 10;
  localparam int unsigned SPECIAL_PROC_TIME_US    = 7000;
  localparam int unsigned WRITE_ZERO_BIT_TIME_US  = 450;
  localparam int unsigned WRITE_ONE_BIT_TIME_US   = 950;

  localparam logic [3:0] BIT_CNT_LAST = 4'h7;
  localparam logic [4:0] SHIFT_TOTAL  = 5'h18;

  typedef enum logic [2:0] {
    OP_READ,
    OP_SPECIAL_READ,
    OP_PROGRAM,
    OP_LOCK
  } rase_op_t;

  typedef enum logic [1:0] {
    OUT_OK,
    OUT_LOCK_FAIL,
    OUT_PROG_UNRELIABLE,
    OUT_LOCK_UNRELIABLE
  } rase_outcome_t;

endpackage : rase_pkg

//--- core/rase_code_map.sv
// Combinational map from operation, outcome and lock state to the read address.
// Assumes inputs come from flops of the same clock domain.
module rase_code_map
  import rase_pkg::*;
(
  input  wire logic [PAGE_W-1:0] i_page,      // Addressed page number
  input  wire rase_op_t          i_op,        // Executed function
  input  wire rase_outcome_t     i_outcome,   // Function outcome
  input  wire logic              i_locked,    // Page lock bit
  output logic      [ADDR_W-1:0] o_addr       // Read address byte
);

  function automatic logic [ADDR_W-1:0] pack(input logic [PAGE_W-1:0] p, input logic [STAT_W-1:0] s);
    pack = {p, s};
  endfunction : pack

  always_comb begin
    o_addr = pack(i_page, ST_READ_UNLOCKED);
    if (i_page == PAGE_ID) begin
      o_addr = pack(i_page, ST_READ_UNLOCKED);
    end else begin
      case (i_outcome)
        OUT_LOCK_FAIL:       o_addr = pack(PAGE_ZERO, ST_READ_UNLOCKED);
        OUT_PROG_UNRELIABLE: o_addr = pack(PAGE_ZERO, ST_PROG_DONE);
        OUT_LOCK_UNRELIABLE: o_addr = pack(PAGE_ZERO, ST_READ_LOCKED);
        default: begin
          // normal codes; special read of page 12
          if (i_op == OP_PROGRAM) begin
            o_addr = pack(i_page, ST_PROG_DONE);
          end else if (i_locked) begin
            o_addr = pack(i_page, ST_READ_LOCKED);
          end else begin
            o_addr = pack(i_page, ST_READ_UNLOCKED);
          end
        end
      endcase
    end
  end

endmodule : rase_code_map

//--- core/rase_encoder.sv
// Read address encoder and tail serializer of the response frame.
// Assumes the frame sequencer has sent pre-bits, start byte and data and
// asserts i_tail_start; the frame check word arrives with it.
module rase_encoder
  import rase_pkg::*;
(
  input  wire logic              i_core_clk,     // Core clock, 100 MHz
  input  wire logic              i_sys_rst,      // Sync reset, active high
  input  wire logic              i_func_valid,   // Pulse: function result ready
  input  wire logic [PAGE_W-1:0] i_page,         // Addressed page
  input  wire rase_op_t          i_op,           // Executed function
  input  wire rase_outcome_t     i_outcome,      // Outcome of the function
  input  wire logic              i_locked,       // Page lock state
  input  wire logic              i_tail_start,   // Pulse: start address and check word
  input  wire logic [CRC_W-1:0]  i_frame_check_word, // Check word, valid with start
  output logic                   o_lsb_only,     // Only low data byte to be sent
  output logic [ADDR_W-1:0]      o_read_addr,    // Latched read address
  output logic                   o_resp_enable,  // Response frame allowed
  output logic                   o_bit,          // Serial tail bit
  output logic                   o_bit_valid,    // Serial bit valid
  output logic                   o_tail_done     // Pulse: last tail bit sent
);

  typedef enum logic [1:0] {
    S_IDLE,
    S_ARMED,
    S_SHIFT
  } rase_state_t;

  typedef struct packed {
    rase_state_t                 state;
    logic [ADDR_W-1:0]           addr;
    logic                        lsb_only;
    logic [ADDR_W+CRC_W-1:0]     shreg;
    logic [4:0]                  cnt;
    logic                        bit_out;
    logic                        bit_valid;
    logic                        done;
  } rase_st_t;

  rase_st_t st_reg;
  rase_st_t st_next;
  logic [ADDR_W-1:0] map_addr;

  rase_code_map u_map (
    .i_page    (i_page),
    .i_op      (i_op),
    .i_outcome (i_outcome),
    .i_locked  (i_locked),
    .o_addr    (map_addr)
  );

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      S_IDLE: begin
        st_next.bit_valid = 1'b0;
        // only a valid function arms a frame
        if (i_func_valid) begin
          st_next.addr     = map_addr;
          // special read of page 12 returns low byte only
          st_next.lsb_only = (i_op == OP_SPECIAL_READ) && (i_page == PAGE_SPECIAL);
          st_next.state    = S_ARMED;
        end
      end
      S_ARMED: begin
        if (i_tail_start) begin
          // address then check word, LSB first
          st_next.shreg     = {i_frame_check_word, st_reg.addr};
          st_next.cnt       = 5'h00;
          st_next.state     = S_SHIFT;
        end
      end
      S_SHIFT: begin
        st_next.bit_out   = st_reg.shreg[0];
        st_next.bit_valid = 1'b1;
        st_next.shreg     = st_reg.shreg >> 1;
        st_next.cnt       = st_reg.cnt + 5'h01;
        if (st_reg.cnt == SHIFT_TOTAL - 5'h01) begin
          st_next.done  = 1'b1;
          st_next.state = S_IDLE;
        end
      end
      default: st_next.state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_reg <= '{state: S_IDLE, addr: '0, lsb_only: 1'b0, shreg: '0, cnt: '0,
                  bit_out: 1'b0, bit_valid: 1'b0, done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_read_addr   = st_reg.addr;
  assign o_lsb_only    = st_reg.lsb_only;
  assign o_resp_enable = (st_reg.state != S_IDLE);
  assign o_bit         = st_reg.bit_out;
  assign o_bit_valid   = st_reg.bit_valid;
  assign o_tail_done   = st_reg.done;

  sequence s_tail_go;
    (st_reg.state == S_ARMED) && i_tail_start;
  endsequence

  sequence s_addr_lsb;
    o_bit_valid && (o_bit == $past(st_reg.addr[0], 1));
  endsequence

  sequence s_check_lsb;
    o_bit_valid && (o_bit == $past(i_frame_check_word[0], 10));
  endsequence

  a_page_status_pack: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && i_outcome == OUT_OK && i_page != PAGE_ID)
      |=> (o_read_addr[PAGE_W+STAT_W-1:STAT_W] == $past(i_page)))
    else $error("page field not in upper bits");

  a_special_unlock: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && i_op == OP_SPECIAL_READ && i_page == PAGE_SPECIAL
     && !i_locked && i_outcome == OUT_OK) |=> (o_read_addr == 8'h30) && o_lsb_only)
    else $error("special unlocked read code wrong");

  a_special_lock: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && i_op == OP_SPECIAL_READ && i_page == PAGE_SPECIAL
     && i_locked && i_outcome == OUT_OK) |=> (o_read_addr == 8'h32) && o_lsb_only)
    else $error("special locked read code wrong");

  a_read_unlocked: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && i_op == OP_READ && !i_locked && i_outcome == OUT_OK)
      |=> (o_read_addr == {$past(i_page), 2'h0}))
    else $error("unlocked read code wrong");

  a_prog_done: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && i_op == OP_PROGRAM && i_outcome == OUT_OK
     && i_page != PAGE_ID) |=> (o_read_addr == {$past(i_page), 2'h1}))
    else $error("programming code wrong");

  a_lock_fail: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && i_outcome == OUT_LOCK_FAIL && i_page != PAGE_ID)
      |=> (o_read_addr == 8'h00))
    else $error("lock failure code not 00");

  a_prog_unrel: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && i_outcome == OUT_PROG_UNRELIABLE && i_page != PAGE_ID)
      |=> (o_read_addr == 8'h01))
    else $error("unreliable programming code not 01");

  a_lock_unrel: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && i_outcome == OUT_LOCK_UNRELIABLE && i_page != PAGE_ID)
      |=> (o_read_addr == 8'h02))
    else $error("unreliable lock code not 02");

  a_tail_order: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_tail_go |=> ##1 s_addr_lsb ##23 (o_bit_valid && o_tail_done))
    else $error("tail not address lsb first then 24 bits");

  a_no_frame_idle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (st_reg.state == S_IDLE && !i_func_valid) |=> !o_resp_enable)
    else $error("response enabled without valid function");

  a_id_page_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && i_page == PAGE_ID) |=> (o_read_addr == 8'h0c))
    else $error("identity page code not 0C");

  a_lsb_only_other: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE && !(i_op == OP_SPECIAL_READ && i_page == PAGE_SPECIAL))
      |=> !o_lsb_only)
    else $error("low byte only flag set outside special read");

  a_func_refused: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state != S_IDLE) |=> ($stable(o_read_addr) && $stable(o_lsb_only)))
    else $error("function accepted while a frame is pending");

  a_check_first: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_tail_go |=> ##9 s_check_lsb)
    else $error("check word lsb not right after address");

  a_check_last: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_tail_go |=> ##24 (o_tail_done && (o_bit == $past(i_frame_check_word[CRC_W-1], 25))))
    else $error("check word msb not the last tail bit");

  a_done_pulse: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_tail_done |=> (!o_tail_done && !o_bit_valid))
    else $error("tail still running after last bit");

  a_armed_enable: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_func_valid && st_reg.state == S_IDLE) |=> o_resp_enable)
    else $error("valid function did not enable a response");

  a_reset_quiet: assert property (@(posedge i_core_clk)
    i_sys_rst |=> (!o_resp_enable && !o_bit_valid && !o_tail_done))
    else $error("response activity after reset");

endmodule : rase_encoder

//--- verif/rase_reader_model.sv
// Reader-side model: collects the serial tail of each response frame.
// Assumes one bit a clock while the bit-valid flag is high.
module rase_reader_model (
  input  wire logic        i_core_clk,  // Core clock
  input  wire logic        i_sys_rst,   // Sync reset, active high
  input  wire logic        i_clear,     // Start a new capture
  input  wire logic        i_bit,       // Serial bit from the device
  input  wire logic        i_bit_valid, // Bit present this cycle
  input  wire logic        i_tail_done, // Last bit marker
  output logic [23:0]      o_frame,     // Captured tail, first bit at 0
  output int               o_nbits,     // Bits received
  output logic             o_done       // Last bit seen
);
  timeunit 1ns;
  timeprecision 1ps;

  always @(posedge i_core_clk) begin
    if (i_sys_rst || i_clear) begin
      o_frame <= 24'h000000;
      o_nbits <= 0;
      o_done  <= 1'b0;
    end else if (i_bit_valid) begin
      o_frame <= {i_bit, o_frame[23:1]};
      o_nbits <= o_nbits + 1;
      o_done  <= i_tail_done;
    end
  end
endmodule : rase_reader_model

//--- verif/tb_top.sv
// Self-checking bench for the read address encoder.
// Assumes the reader model captures the serial tail.
module tb_top
  import rase_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              fv  = 1'b0;
  logic              ts  = 1'b0;
  logic              lk  = 1'b0;
  logic              clr = 1'b0;
  logic [PAGE_W-1:0] pg  = 6'h00;
  rase_op_t          op  = OP_READ;
  rase_outcome_t     oc  = OUT_OK;
  logic [CRC_W-1:0]  crc = 16'h0000;
  logic              lsb, ren, bt, bv, tdone, rx_done;
  logic [ADDR_W-1:0] addr;
  logic [23:0]       rx_frame;
  int                rx_n;
  int                error_cnt  = 0;
  int                n_compared = 0;
  logic [5:0]        pages[8] = '{6'h01, 6'h02, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c};

  always #5 clk = ~clk;

  rase_encoder dut_u (
    .i_core_clk(clk), .i_sys_rst(rst), .i_func_valid(fv), .i_page(pg), .i_op(op),
    .i_outcome(oc), .i_locked(lk), .i_tail_start(ts), .i_frame_check_word(crc),
    .o_lsb_only(lsb), .o_read_addr(addr), .o_resp_enable(ren), .o_bit(bt),
    .o_bit_valid(bv), .o_tail_done(tdone)
  );

  rase_reader_model rdr_u (
    .i_core_clk(clk), .i_sys_rst(rst), .i_clear(clr), .i_bit(bt), .i_bit_valid(bv),
    .i_tail_done(tdone), .o_frame(rx_frame), .o_nbits(rx_n), .o_done(rx_done)
  );

  // Outcome codes win over the operation; identity page is fixed
  function automatic logic [7:0] model(input logic [5:0] p, input int o, input int c, input int l);
    if (p == PAGE_ID) return 8'h0c;
    if (c != 0) return 8'(c - 1);
    if (o == 2) return {p, 2'h1};
    return {p, (l != 0) ? 2'h2 : 2'h0};
  endfunction : model

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    int         i, k, pi, oi, ci, li;
    logic [7:0] e;
    void'($urandom(32'h1d71bc23));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) ts <= 1'b1;
    @(posedge clk) ts <= 1'b0;
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk(rx_n, 0);
    chk(ren, 0);
    for (i = 0; i < 128; i++) begin
      pi = i % 8;
      oi = (i >> 3) % 4;
      // Both lock states for every op before random outcomes
      ci = (i < 64) ? 0 : $urandom % 4;
      li = (i < 64) ? (i >> 5) % 2 : $urandom % 2;
      // write bits at minimum length, one clock per 100 us
      // full keying implied: the function pulse is the decoded write
      for (k = 0; k < 8; k++) begin
        repeat ((($urandom % 2) != 0) ? WRITE_ONE_BIT_TIME_US / 100 : WRITE_ZERO_BIT_TIME_US / 100) @(posedge clk);
      end
      @(posedge clk);
      fv  <= 1'b1;
      pg  <= pages[pi];
      op  <= rase_op_t'(oi);
      oc  <= rase_outcome_t'(ci);
      lk  <= li[0];
      clr <= 1'b1;
      @(posedge clk);
      fv  <= 1'b0;
      clr <= 1'b0;
      @(negedge clk);
      e = model(pages[pi], oi, ci, li);
      chk(addr, e);
      chk(lsb, oi == 1 && pi == 7);
      chk(ren, 1);
      // Second function while armed must be ignored
      @(posedge clk);
      fv <= 1'b1;
      pg <= 6'h08;
      op <= OP_PROGRAM;
      oc <= OUT_OK;
      @(posedge clk);
      fv  <= 1'b0;
      // special-read processing gap before the reply, one clock per 100 us
      if (oi == 1) repeat (SPECIAL_PROC_TIME_US / 100) @(posedge clk);
      crc <= 16'($urandom);
      ts  <= 1'b1;
      @(posedge clk) ts <= 1'b0;
      @(negedge clk);
      chk(addr, e);
      for (k = 0; k < 40 && rx_done !== 1'b1; k++) @(negedge clk);
      if (rx_done !== 1'b1) begin
        error_cnt++;
        close_out();
      end
      chk(rx_n, 24);
      chk(rx_frame, {crc, e});
      @(negedge clk);
      chk(ren, 0);
      chk(bv, 0);
    end
    // Reset while armed drops the pending frame
    @(posedge clk);
    fv <= 1'b1;
    pg <= PAGE_SPECIAL;
    op <= OP_SPECIAL_READ;
    oc <= OUT_OK;
    @(posedge clk);
    fv  <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(ren, 0);
    chk(addr, 0);
    chk(lsb, 0);
    @(posedge clk) ts <= 1'b1;
    @(posedge clk) ts <= 1'b0;
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk(rx_n, 0);
    close_out();
  end
endmodule : tb_top
